// >>> core/ret_rot_pkg.sv
// constants and types for the return and rotate execution block
// Overview of operation
// - interrupt return pops stack into program counter
// - interrupt return also sets global interrupt enable
// - subroutine return pops stack, touches nothing else
// - literal return loads accumulator and pops stack
// - rotate left, carry in low, msb out
// - target flag selects accumulator or register writeback
// - rotate: 7-bit address, carry only, one cycle
`default_nettype none
package ret_rot_pkg;
    localparam int PC_WIDTH = 13;
    localparam int STACK_DEPTH = 16;
    localparam int SP_WIDTH = 4;
    localparam int FILE_ADDR_WIDTH = 7;
    localparam int DATA_WIDTH = 8;
    localparam int RETURN_CYCLES = 2;
    localparam int ROTATE_CYCLES = 1;
    localparam int GLOBAL_INTERRUPT_ENABLE_BIT = 7;
    localparam logic [PC_WIDTH-1:0] PC_RESET = 13'h0000;
    localparam logic [SP_WIDTH-1:0] SP_RESET = 4'h0;
    localparam logic [DATA_WIDTH-1:0] ACC_RESET = 8'h00;
    localparam logic CARRY_RESET = 1'b0;
    localparam logic TARGET_ACCUMULATOR = 1'b0;
    localparam logic TARGET_REGISTER = 1'b1;

    // operation requested by the fetch/decode stage
    typedef enum logic [3:0] {
        OP_NONE = 4'h0,
        OP_RETURN_FROM_INTERRUPT = 4'h1,
        OP_RETURN_FROM_SUBROUTINE = 4'h2,
        OP_RETURN_WITH_LITERAL = 4'h3,
        OP_ROTATE_LEFT_THROUGH_CARRY = 4'h4
    } opcode_type;

    // one-hot execution states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_SECOND = 2'b10
    } exec_state_type;
endpackage
`default_nettype wire

// >>> core/return_stack_mem.sv
// small return address memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module return_stack_mem
    import ret_rot_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH,
    parameter int AW = SP_WIDTH,
    parameter int DW = PC_WIDTH
) (
    input wire logic mclk,
    input wire logic writeEnable,
    input wire logic [AW-1:0] writeAddr,
    input wire logic [DW-1:0] writeData,
    input wire logic [AW-1:0] readAddr,
    output logic [DW-1:0] readData
);
    logic [DW-1:0] entries [DEPTH];

    // no reset on storage; read data is one cycle behind the address
    always_ff @(posedge mclk) begin
        if (writeEnable) begin
            entries[writeAddr] <= writeData;
        end
        readData <= entries[readAddr];
    end
endmodule
`default_nettype wire

// >>> core/return_and_rotate_execution.sv
// execution of the three returns and rotate left through carry
`timescale 1ns/10ps
`default_nettype none
module return_and_rotate_execution
    import ret_rot_pkg::*;
#(
    parameter int DEPTH = STACK_DEPTH
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic opValid,
    input wire opcode_type opCode,
    input wire logic [DATA_WIDTH-1:0] literal,
    input wire logic [FILE_ADDR_WIDTH-1:0] fileAddr,
    input wire logic resultTarget,
    input wire logic [DATA_WIDTH-1:0] fileData,
    input wire logic pushValid,
    input wire logic [PC_WIDTH-1:0] pushAddr,
    output logic opReady,
    output logic [PC_WIDTH-1:0] programCounter,
    output logic pcLoad,
    output logic [DATA_WIDTH-1:0] accumulator,
    output logic carryFlag,
    output logic globalInterruptEnableSet,
    output logic fileWriteEnable,
    output logic [FILE_ADDR_WIDTH-1:0] fileWriteAddr,
    output logic [DATA_WIDTH-1:0] fileWriteData,
    output logic [SP_WIDTH-1:0] stackPointer
);
    ////////////////////////////////////////////////////////////////////////
    // behaviour notes for whoever drives this block
    //
    // request handshake
    // - a request is taken at a rising edge with opValid and opReady high
    // - opValid while opReady is low is dropped without any sign
    // - codes other than the four operations are ignored in idle
    // - opCode, literal and fileData need only stand in the take cycle
    // - opReady never depends on opValid, so no loop forms through the caller
    //
    // rotate left through carry, one cycle
    // - cycle 0: opCode, fileData, fileAddr and resultTarget stand
    // - cycle 1: carryFlag plus accumulator or the write port updated
    // - the write port keeps address and data; only the enable pulses
    // - back-to-back rotates chain through the registered carry
    // - fileAddr is passed through unchecked; all seven bits are legal
    // - no other status bit is touched; those live outside this block
    //
    // returns, two cycles
    // - cycle 0: the top entry is read out of the stack memory
    // - cycle 1: opReady low, nothing new is taken
    // - cycle 2: pcLoad pulses with the popped entry in programCounter
    // - cycle 2: stackPointer one lower, accumulator or enable pulse updated
    // - the enable pulse only asks for the global enable bit to be set;
    //   the interrupt control register itself lives outside
    // - returns leave carry and every other status bit alone
    //
    // pushes
    // - pushValid writes pushAddr into the slot that stackPointer names
    // - the read port is registered, which costs a return its second
    //   cycle but keeps the storage a plain synchronous memory
    // - a return taken at the same edge as a push pops the older entry;
    //   keep the two at least one cycle apart
    // - a push during a return's second cycle is lost, the pop wins
    //
    // stack memory
    // - depth comes from a parameter; the pointer is four bits wide
    // - storage has no reset, so a pop before any push returns junk
    // - that junk can only reach programCounter, never the flags
    //
    // outputs
    // - pcLoad, the enable pulse and fileWriteEnable stand one cycle
    // - programCounter, accumulator and the write port hold until changed
    // - opReady is combinational from the state, so it settles early
    //
    // reset
    // - every register except the stack memory clears asynchronously; opReady is high at once
    // - a request may be made at the first edge after release
    //
    // limitations
    // - the stack pointer wraps silently; no overflow or underflow reset
    // - nothing here ever clears the global enable bit
    // - refused requests give no error; the caller must watch opReady
    ////////////////////////////////////////////////////////////////////////

    // state, registered outputs and their next values
    exec_state_type state, next_state;
    logic [SP_WIDTH-1:0] next_stackPointer;
    logic [PC_WIDTH-1:0] next_programCounter;
    logic next_pcLoad;
    logic [DATA_WIDTH-1:0] next_accumulator;
    logic next_carryFlag;
    logic next_globalInterruptEnableSet;
    logic next_fileWriteEnable;
    logic [FILE_ADDR_WIDTH-1:0] next_fileWriteAddr;
    logic [DATA_WIDTH-1:0] next_fileWriteData;
    opcode_type pendingOp, next_pendingOp;
    logic [DATA_WIDTH-1:0] pendingLiteral, next_pendingLiteral;
    logic [SP_WIDTH-1:0] popIndex;
    logic [PC_WIDTH-1:0] poppedReturnEntry;
    logic [DATA_WIDTH-1:0] rotated;
    logic rotateCarry;
    logic isReturn;

    // stack pointer points at next free slot, so top sits one below
    function automatic logic [SP_WIDTH-1:0] below(input logic [SP_WIDTH-1:0] sp);
        return sp - 4'h1;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // return address storage
    assign popIndex = below(stackPointer);

    return_stack_mem #(
        .DEPTH(DEPTH),
        .AW(SP_WIDTH),
        .DW(PC_WIDTH)
    ) stackMem (
        .mclk(mclk),
        .writeEnable(pushValid),
        .writeAddr(stackPointer),
        .writeData(pushAddr),
        .readAddr(popIndex),
        .readData(poppedReturnEntry)
    );

    ////////////////////////////////////////////////////////////////////////
    // rotate datapath: old carry enters bit 0, old bit 7 leaves to carry
    assign rotated = {fileData[DATA_WIDTH-2:0], carryFlag};
    assign rotateCarry = fileData[DATA_WIDTH-1];

    assign isReturn = (opCode == OP_RETURN_FROM_INTERRUPT) ||
                      (opCode == OP_RETURN_FROM_SUBROUTINE) ||
                      (opCode == OP_RETURN_WITH_LITERAL);

    // a return occupies the second cycle, so new work waits
    assign opReady = (state == ST_IDLE);

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        next_state = state;
        next_stackPointer = stackPointer;
        next_programCounter = programCounter;
        next_pcLoad = 1'b0;
        next_accumulator = accumulator;
        next_carryFlag = carryFlag;
        next_globalInterruptEnableSet = 1'b0;
        next_fileWriteEnable = 1'b0;
        next_fileWriteAddr = fileWriteAddr;
        next_fileWriteData = fileWriteData;
        next_pendingOp = pendingOp;
        next_pendingLiteral = pendingLiteral;
        if (pushValid) begin
            next_stackPointer = stackPointer + 4'h1;
        end
        unique case (state)
            ST_IDLE: begin
                if (opValid && isReturn) begin
                    // first cycle: memory is reading the top entry
                    next_pendingOp = opCode;
                    next_pendingLiteral = literal;
                    next_state = ST_SECOND;
                end else if (opValid && opCode == OP_ROTATE_LEFT_THROUGH_CARRY) begin
                    next_carryFlag = rotateCarry;
                    if (resultTarget == TARGET_REGISTER) begin
                        next_fileWriteEnable = 1'b1;
                        next_fileWriteAddr = fileAddr;
                        next_fileWriteData = rotated;
                    end else begin
                        next_accumulator = rotated;
                    end
                end
            end
            ST_SECOND: begin
                // second cycle: top entry valid, pop completes
                next_programCounter = poppedReturnEntry;
                next_pcLoad = 1'b1;
                next_stackPointer = popIndex;
                if (pendingOp == OP_RETURN_FROM_INTERRUPT) begin
                    next_globalInterruptEnableSet = 1'b1;
                end
                if (pendingOp == OP_RETURN_WITH_LITERAL) begin
                    next_accumulator = pendingLiteral;
                end
                next_state = ST_IDLE;
            end
        endcase
    end

    // registers only
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_IDLE;
            stackPointer <= SP_RESET;
            programCounter <= PC_RESET;
            pcLoad <= 1'b0;
            accumulator <= ACC_RESET;
            carryFlag <= CARRY_RESET;
            globalInterruptEnableSet <= 1'b0;
            fileWriteEnable <= 1'b0;
            fileWriteAddr <= '0;
            fileWriteData <= '0;
            pendingOp <= OP_NONE;
            pendingLiteral <= '0;
        end else begin
            state <= next_state;
            stackPointer <= next_stackPointer;
            programCounter <= next_programCounter;
            pcLoad <= next_pcLoad;
            accumulator <= next_accumulator;
            carryFlag <= next_carryFlag;
            globalInterruptEnableSet <= next_globalInterruptEnableSet;
            fileWriteEnable <= next_fileWriteEnable;
            fileWriteAddr <= next_fileWriteAddr;
            fileWriteData <= next_fileWriteData;
            pendingOp <= next_pendingOp;
            pendingLiteral <= next_pendingLiteral;
        end
    end
endmodule
`default_nettype wire

// >>> bench/return_and_rotate_assertions.sv
// concurrent checks on the ports of the return and rotate block
`timescale 1ns/10ps
`default_nettype none
module return_and_rotate_assertions
    import ret_rot_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic opValid,
    input wire logic opReady,
    input wire logic resultTarget,
    input wire logic pcLoad,
    input wire logic carryFlag,
    input wire logic globalInterruptEnableSet,
    input wire logic fileWriteEnable,
    input wire opcode_type opCode,
    input wire logic [7:0] accumulator,
    input wire logic [7:0] fileData,
    input wire logic [7:0] literal,
    input wire logic [7:0] fileWriteData,
    input wire logic [3:0] stackPointer
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    // a request counts only when the block is idle
    logic take;
    assign take = opValid && opReady;
    enable_with_load_a: assert property (globalInterruptEnableSet |-> pcLoad)
        else $error("enable pulse without load");
    ret_two_cycle_a: assert property (take && opCode inside {4'h1, 4'h2, 4'h3}
        |=> !opReady ##1 (pcLoad && opReady)) else $error("return timing");
    ret_enable_a: assert property (take && opCode == 4'h1 |-> ##2 globalInterruptEnableSet)
        else $error("no enable on interrupt return");
    sub_no_enable_a: assert property (take && opCode inside {4'h2, 4'h3} |-> ##2
        !globalInterruptEnableSet && carryFlag == $past(carryFlag, 2))
        else $error("plain return touched state");
    pop_sp_a: assert property (pcLoad |-> stackPointer == $past(stackPointer) - 4'h1)
        else $error("pop step wrong");
    lit_acc_a: assert property (take && opCode == 4'h3 |-> ##2 accumulator == $past(literal, 2))
        else $error("literal not in accumulator");
    rot_acc_a: assert property (take && opCode == 4'h4 && !resultTarget
        |=> opReady && !fileWriteEnable
        && accumulator == {$past(fileData[6:0]), $past(carryFlag)} && carryFlag == $past(fileData[7]))
        else $error("rotate to accumulator");
    rot_reg_a: assert property (take && opCode == 4'h4 && resultTarget |=> fileWriteEnable
        && fileWriteData == {$past(fileData[6:0]), $past(carryFlag)} && $stable(accumulator))
        else $error("rotate to register");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind return_and_rotate_execution return_and_rotate_assertions chk (.mclk(mclk), .resetn(resetn),
    .opValid(opValid), .opReady(opReady), .resultTarget(resultTarget), .pcLoad(pcLoad),
    .carryFlag(carryFlag), .globalInterruptEnableSet(globalInterruptEnableSet),
    .fileWriteEnable(fileWriteEnable), .opCode(opCode), .accumulator(accumulator),
    .fileData(fileData), .literal(literal), .fileWriteData(fileWriteData),
    .stackPointer(stackPointer));
`default_nettype wire

// >>> bench/tb.sv
// self-checking bench for the return and rotate block
`timescale 1ns/10ps
`default_nettype none
module tb
    import ret_rot_pkg::*;
;
    logic mclk = 1'b0, resetn = 1'b0, opValid = 1'b0, resultTarget = 1'b0, pushValid = 1'b0;
    opcode_type opCode = OP_NONE;
    logic [7:0] literal = 8'h00, fileData = 8'h00, acc, wdata;
    logic [6:0] fileAddr = 7'h00, waddr;
    logic [12:0] pushAddr = 13'h0000, pc;
    logic rdy, load, carry, enableSet, wen;
    logic [3:0] sp;
    int err_count = 0, check_count = 0;
    return_and_rotate_execution uut (.mclk(mclk), .resetn(resetn), .opValid(opValid),
        .opCode(opCode), .literal(literal), .fileAddr(fileAddr), .resultTarget(resultTarget),
        .fileData(fileData), .pushValid(pushValid), .pushAddr(pushAddr), .opReady(rdy),
        .programCounter(pc), .pcLoad(load), .accumulator(acc), .carryFlag(carry),
        .globalInterruptEnableSet(enableSet), .fileWriteEnable(wen), .fileWriteAddr(waddr),
        .fileWriteData(wdata), .stackPointer(sp));
    always #4 mclk = ~mclk;
    // compare and count
    task chk(input string n, input logic [12:0] e, input logic [12:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task push(input logic [12:0] a);
        @(posedge mclk);
        pushValid <= 1'b1;
        pushAddr <= a;
        @(posedge mclk);
        pushValid <= 1'b0;
    endtask
    // one request, left on the take edge; returns after its results land
    task issue(input opcode_type c, input logic [7:0] l, d, input logic t);
        @(posedge mclk);
        opValid <= 1'b1;
        opCode <= c;
        literal <= l;
        fileData <= d;
        resultTarget <= t;
        fileAddr <= 7'h7f;
        @(posedge mclk);
        opValid <= 1'b0;
        if (c != OP_ROTATE_LEFT_THROUGH_CARRY) @(posedge mclk);
        #1;
    endtask
    // three pushes unwound in reverse order by each kind of return
    task test_returns;
        push(13'h0123); push(13'h0456); push(13'h0789);
        #1 chk("sp", 13'h3, {9'h0, sp});
        issue(OP_RETURN_FROM_INTERRUPT, 8'h00, 8'h00, 0);
        chk("pc", 13'h0789, pc); chk("enableSet", 13'h1, {12'h0, enableSet});
        chk("load", 13'h1, {12'h0, load}); chk("sp", 13'h2, {9'h0, sp});
        issue(OP_RETURN_FROM_SUBROUTINE, 8'h00, 8'h00, 0);
        chk("pc", 13'h0456, pc); chk("enableSet", 13'h0, {12'h0, enableSet});
        issue(OP_RETURN_WITH_LITERAL, 8'hff, 8'h00, 0);
        chk("pc", 13'h0123, pc); chk("acc", 13'h0ff, {5'h0, acc});
        chk("sp", 13'h0, {9'h0, sp}); chk("carry", 13'h0, {12'h0, carry});
    endtask
    // rotate into accumulator then into the register at the top address
    task test_rotate;
        issue(OP_ROTATE_LEFT_THROUGH_CARRY, 8'h00, 8'he6, 0);
        chk("acc", 13'h0cc, {5'h0, acc}); chk("carry", 13'h1, {12'h0, carry});
        chk("wen", 13'h0, {12'h0, wen}); chk("rdy", 13'h1, {12'h0, rdy});
        issue(OP_ROTATE_LEFT_THROUGH_CARRY, 8'h00, 8'h55, 1);
        chk("wdata", 13'h0ab, {5'h0, wdata}); chk("wen", 13'h1, {12'h0, wen});
        chk("waddr", 13'h07f, {6'h0, waddr}); chk("acc", 13'h0cc, {5'h0, acc});
        chk("carry", 13'h0, {12'h0, carry});
    endtask
    task results;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // a hang would otherwise never reach the verdict
    initial begin
        #100000;
        err_count++;
        results;
    end
    initial begin
        repeat (4) @(posedge mclk);
        resetn <= 1'b1;
        test_returns;
        test_rotate;
        results;
    end
endmodule
`default_nettype wire
